// ### tport_pkg.sv
// Purpose: Constants and carrier types for the timer-shared 8-bit I/O port
// Assumes: Byte-wide register port, one bus clock
// Notes: Offsets are register indices on the plain register port
package tport_pkg;
	localparam int unsigned port_width = 8;
	localparam int unsigned routed_pins = 5;
	localparam int unsigned addr_width = 3;
	localparam logic [2:0] off_output_value = 3'h0;
	localparam logic [2:0] off_pin_input = 3'h1;
	localparam logic [2:0] off_direction = 3'h2;
	localparam logic [2:0] off_reduced_drive = 3'h3;
	localparam logic [2:0] off_pull_enable = 3'h4;
	localparam logic [2:0] off_polarity_select = 3'h5;
	localparam logic [2:0] off_routing_select = 3'h7;
	localparam logic [7:0] rst_byte = 8'h00;
	localparam logic [7:0] unmapped_read = 8'h00;

	// Which peripheral drives a pin
	typedef enum logic [1:0] {
		src_gpio,
		src_timer,
		src_pwm
	} pin_source_e;

	// Register port request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	// Per-pin pad controls
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] reduced;
		logic [7:0] pull_up;
		logic [7:0] pull_down;
	} pad_ctrl_s;
endpackage

// ### timer_shared_io_port.sv
// Purpose: 8-bit general-purpose port whose pins are shared with timer and PWM outputs
// Assumes: Pins are asynchronous and pass a two-stage synchroniser before use
// Notes: Timer and PWM control levels come from logic on the same clock
//
// Summary of operation
// - Input pin with pull enable: polarity 0 pull-up, 1 pull-down.
// - Output pin drives latch at full or reduced strength, pull disabled.
// - This port has no pin interrupt logic at all.
// - Every register bit reads synchronously to the bus clock.
// - Output-value read gives latch where direction is 1, else pin level.
// - A timer output channel takes the pin from the general latch.
// - Pins 4..0: PWM if routed and enabled, else timer if active, else GPIO.
// - Timer active needs global enable, compare or toggle mode, and routing.
// - Pin-input register is read-only; writes change nothing.
// - Pin-input read always gives the sampled pin level.
// - Direction bit 0 makes input, 1 output, unless a peripheral overrides.
// - Owning timer or PWM output forces output, stored direction kept.
// - When compare output disables, stored direction controls again.
// - Pin level always feeds timer input capture.
// - Reads may lag a direction change by up to three bus cycles.
// - Reduced-drive bit: 0 full, 1 about one third; ignored for inputs.
// - Routing bit 0 connects timer, 1 connects PWM on pins 4..0.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module timer_shared_io_port #(
	parameter int unsigned width = tport_pkg::port_width,
	parameter int unsigned routed = tport_pkg::routed_pins
) (
	input wire logic clk,
	input wire logic srst,
	// Register port
	input wire logic [tport_pkg::addr_width-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Pads
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] pin_reduced,
	output logic [7:0] pin_pull_up,
	output logic [7:0] pin_pull_down,
	// Timer unit
	input wire logic timer_global_enable,
	input wire logic [7:0] timer_compare_select,
	input wire logic [7:0] timer_overflow_toggle,
	input wire logic [7:0] timer_action_routed,
	input wire logic [7:0] timer_out,
	output logic [7:0] capture_in,
	// PWM unit
	input wire logic [7:0] pwm_channel_enable,
	input wire logic [7:0] pwm_out
);
	// The pad and register paths are byte-wide; only the routed count may shrink
	if (width != tport_pkg::port_width || routed > width || routed == 0) begin : g_bad_params
		$error("timer_shared_io_port: unsupported width or routed pin count");
	end

	logic [7:0] output_value_q;
	logic [7:0] direction_q;
	logic [7:0] reduced_drive_q;
	logic [7:0] pull_enable_q;
	logic [7:0] polarity_select_q;
	logic [7:0] routing_select_q;
	logic [7:0] sync1_q;
	logic [7:0] sync2_q;
	logic [7:0] timer_output_active;
	logic [7:0] drive_d;
	logic [7:0] own_d;
	tport_pkg::pad_ctrl_s pad_d;
	tport_pkg::pad_ctrl_s pad_q;

	function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
		return a == off;
	endfunction

	// Pin synchroniser; first stage feeds only the second
	always_ff @(posedge clk) begin
		if (srst) begin
			sync1_q <= tport_pkg::rst_byte;
			sync2_q <= tport_pkg::rst_byte;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// Software registers; the pin-input offset has no write decode at all
	always_ff @(posedge clk) begin
		if (srst) begin
			output_value_q <= tport_pkg::rst_byte;
			direction_q <= tport_pkg::rst_byte;
			reduced_drive_q <= tport_pkg::rst_byte;
			pull_enable_q <= tport_pkg::rst_byte;
			polarity_select_q <= tport_pkg::rst_byte;
			routing_select_q <= tport_pkg::rst_byte;
		end else if (reg_wr) begin
			if (hit(reg_addr, tport_pkg::off_output_value)) begin
				output_value_q <= reg_wdata;
			end
			if (hit(reg_addr, tport_pkg::off_direction)) begin
				direction_q <= reg_wdata;
			end
			if (hit(reg_addr, tport_pkg::off_reduced_drive)) begin
				reduced_drive_q <= reg_wdata;
			end
			if (hit(reg_addr, tport_pkg::off_pull_enable)) begin
				pull_enable_q <= reg_wdata;
			end
			if (hit(reg_addr, tport_pkg::off_polarity_select)) begin
				polarity_select_q <= reg_wdata;
			end
			if (hit(reg_addr, tport_pkg::off_routing_select)) begin
				// Upper bits have no routing mux and read as zero
				routing_select_q <= reg_wdata & 8'((1 << routed) - 1);
			end
		end
	end
	// Writes to the pin-input offset fall through untouched

	// Per-pin function select
	for (genvar i = 0; i < 8; i++) begin : g_pin
		tport_pkg::pin_source_e src;
		always_comb begin
			timer_output_active[i] = timer_global_enable
				&& (timer_compare_select[i] || timer_overflow_toggle[i])
				&& timer_action_routed[i];
			src = tport_pkg::src_gpio;
			if (i < routed && routing_select_q[i] && pwm_channel_enable[i]) begin
				src = tport_pkg::src_pwm;
			end else if (timer_output_active[i]) begin
				src = tport_pkg::src_timer;
			end
			case (src)
				tport_pkg::src_pwm: begin
					drive_d[i] = pwm_out[i];
					own_d[i] = 1'b1;
				end
				tport_pkg::src_timer: begin
					drive_d[i] = timer_out[i];
					own_d[i] = 1'b1;
				end
				default: begin
					drive_d[i] = output_value_q[i];
					own_d[i] = 1'b0;
				end
			endcase
		end
	end

	// Pad controls; polarity select only picks the pull, no edge detection here
	always_comb begin
		pad_d.out = drive_d;
		pad_d.oe = direction_q | own_d;
		pad_d.reduced = reduced_drive_q & pad_d.oe;
		pad_d.pull_up = pull_enable_q & ~polarity_select_q & ~pad_d.oe;
		pad_d.pull_down = pull_enable_q & polarity_select_q & ~pad_d.oe;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pad_q <= '0;
		end else begin
			pad_q <= pad_d;
		end
	end

	assign pin_out = pad_q.out;
	assign pin_oe = pad_q.oe;
	assign pin_reduced = pad_q.reduced;
	assign pin_pull_up = pad_q.pull_up;
	assign pin_pull_down = pad_q.pull_down;

	// Capture path sees the pin whatever drives it
	always_ff @(posedge clk) begin
		if (srst) begin
			capture_in <= tport_pkg::rst_byte;
		end else begin
			capture_in <= sync2_q;
		end
	end

	// Read data from synchronised levels only; lag after a direction write is the pad register plus the sync depth
	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata <= tport_pkg::unmapped_read;
		end else if (reg_rd) begin
			case (reg_addr)
				tport_pkg::off_output_value: begin
					reg_rdata <= (direction_q & output_value_q) | (~direction_q & sync2_q);
				end
				tport_pkg::off_pin_input: reg_rdata <= sync2_q;
				tport_pkg::off_direction: reg_rdata <= direction_q;
				tport_pkg::off_reduced_drive: reg_rdata <= reduced_drive_q;
				tport_pkg::off_pull_enable: reg_rdata <= pull_enable_q;
				tport_pkg::off_polarity_select: reg_rdata <= polarity_select_q;
				tport_pkg::off_routing_select: reg_rdata <= routing_select_q;
				default: reg_rdata <= tport_pkg::unmapped_read;
			endcase
		end else begin
			reg_rdata <= tport_pkg::unmapped_read;
		end
	end
endmodule

// ### tport_props.sv
// Purpose: Port-level checks of the timer-shared port
// Assumes: Sees only top-level ports
// Notes: Timer output is checked on pins 7..5, where no routing applies
`timescale 1ns/1ps
module tport_props (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Pads
	input wire logic [7:0] pin_in,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_reduced,
	input wire logic [7:0] pin_pull_up,
	input wire logic [7:0] pin_pull_down,
	// Timer unit
	input wire logic timer_global_enable,
	input wire logic [7:0] timer_compare_select,
	input wire logic [7:0] timer_overflow_toggle,
	input wire logic [7:0] timer_action_routed,
	input wire logic [7:0] timer_out,
	input wire logic [7:0] capture_in
);
	logic [7:0] act;
	assign act = {8{timer_global_enable}} & (timer_compare_select | timer_overflow_toggle)
		& timer_action_routed;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// Synchroniser history is only meaningful after three quiet edges
	sequence s_calm; !srst [*3]; endsequence
	sequence s_pin_rd; reg_rd && reg_addr == 3'h1; endsequence
	property p_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
	property p_pin; s_calm ##0 s_pin_rd |=> reg_rdata == $past(pin_in, 3); endproperty
	property p_cap; s_calm |=> capture_in == $past(pin_in, 3); endproperty
	property p_pull_oe; (pin_oe & (pin_pull_up | pin_pull_down)) == 8'h00; endproperty
	property p_pull2; (pin_pull_up & pin_pull_down) == 8'h00; endproperty
	property p_red; (pin_reduced & ~pin_oe) == 8'h00; endproperty
	property p_own; act != 8'h00 |=> (pin_oe & $past(act)) == $past(act); endproperty
	property p_tout; act[7:5] != 3'h0 |=>
		((pin_out ^ $past(timer_out)) & $past(act) & 8'he0) == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data outside read cycle");
	a_pin: assert property (p_pin) else $error("pin input read wrong");
	a_cap: assert property (p_cap) else $error("capture level wrong");
	a_pull_oe: assert property (p_pull_oe) else $error("pull on output");
	a_pull2: assert property (p_pull2) else $error("both pulls on");
	a_red: assert property (p_red) else $error("reduced drive on input");
	a_own: assert property (p_own) else $error("owned pin not output");
	a_tout: assert property (p_tout) else $error("timer level not on pin");
endmodule
bind timer_shared_io_port tport_props chk_u (.*);

// ### tport_pads.sv
// Purpose: Pad model for the port pins
// Assumes: A pin without driver or pull floats
// Notes: A floating pin flips every cycle, so nothing can rely on it
`timescale 1ns/1ps
module tport_pads (
	// Clock
	input wire logic clk,
	// Pad controls
	input tport_pkg::pad_ctrl_s pad,
	// Pin levels
	output logic [7:0] level
);
	logic [7:0] float_q = 8'h5a;
	always @(posedge clk) float_q <= ~float_q;
	assign level = (pad.oe & pad.out) | (~pad.oe & (pad.pull_up | (~pad.pull_down & float_q)));
endmodule

// ### timer_shared_io_port_test.sv
// Purpose: Self-checking bench for the timer-shared port
// Assumes: Pins closed by the pad model
// Notes: Floating pins are never compared
`timescale 1ns/1ps
module timer_shared_io_port_test;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_q = 1'b0;
	logic pc = 1'b0;
	logic timer_global_enable = 1'b0;
	logic [7:0] timer_compare_select = 8'h00, timer_overflow_toggle = 8'h00;
	logic [7:0] timer_action_routed = 8'h00, timer_out = 8'h00;
	logic [7:0] pwm_channel_enable = 8'h00, pwm_out = 8'h00;
	logic [7:0] reg_rdata, pin_in, pin_out, pin_oe, pin_reduced, pin_pull_up, pin_pull_down;
	logic [7:0] capture_in, lv, tv, pv;
	logic [7:0] rd_e[$], oe_e[$], out_e[$];
	logic [23:0] aux_e[$];
	int errors = 0, checked = 0;
	integer seed = 32'hfeb8;
	always #50 clk = ~clk;
	timer_shared_io_port dut_u (.*);
	tport_pads pads_u (.clk(clk), .level(pin_in),
		.pad({pin_out, pin_oe, pin_reduced, pin_pull_up, pin_pull_down}));
	task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		if (!w) rd_e.push_back(d);
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask
	task automatic pad(input logic [7:0] oe, input logic [7:0] out, input logic [23:0] aux);
		repeat (3) @(posedge clk);
		oe_e.push_back(oe);
		out_e.push_back(out);
		aux_e.push_back(aux);
		pc <= 1'b1;
		@(posedge clk);
		pc <= 1'b0;
	endtask
	task automatic bad(input logic [7:0] got, input logic [7:0] exp);
		errors++;
		$display("unexpected %0t got %h want %h", $time, got, exp);
	endtask
	task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) bad(got, exp);
	endtask
	task automatic cmp_pad(input logic [7:0] oe, input logic [7:0] out, input logic [23:0] aux);
		checked++;
		if (pin_oe !== oe) bad(pin_oe, oe);
		if ((pin_out & oe) !== out) bad(pin_out, out);
		if (pin_reduced !== aux[23:16]) bad(pin_reduced, aux[23:16]);
		if (pin_pull_up !== aux[15:8]) bad(pin_pull_up, aux[15:8]);
		if (pin_pull_down !== aux[7:0]) bad(pin_pull_down, aux[7:0]);
	endtask
	always @(posedge clk) begin
		if (rd_q) cmp_rd(reg_rdata, rd_e.pop_front());
		if (pc) cmp_pad(oe_e.pop_front(), out_e.pop_front(), aux_e.pop_front());
		rd_q <= reg_rd;
	end
	task automatic print_verdict;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#500000;
		errors++;
		print_verdict;
	end
	initial begin
		lv = $random(seed);
		tv = $random(seed);
		pv = $random(seed);
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		bus(1'b1, 3'h6, 8'hff);
		bus(1'b1, 3'h7, 8'hff);
		for (int a = 2; a < 7; a++) bus(1'b0, a[2:0], tport_pkg::rst_byte);
		bus(1'b0, 3'h7, 8'h1f);
		bus(1'b1, 3'h2, 8'hff);
		bus(1'b1, 3'h0, lv);
		bus(1'b1, 3'h3, 8'h0f);
		bus(1'b1, 3'h1, ~lv);
		pad(8'hff, lv, 24'h0f0000);
		bus(1'b0, 3'h0, lv);
		bus(1'b0, 3'h1, lv);
		bus(1'b0, 3'h3, 8'h0f);
		bus(1'b1, 3'h2, 8'h40);
		bus(1'b1, 3'h4, 8'hbf);
		bus(1'b1, 3'h5, 8'h0f);
		pad(8'h40, lv & 8'h40, 24'h00b00f);
		bus(1'b0, 3'h1, 8'hb0 | (lv & 8'h40));
		bus(1'b0, 3'h0, 8'hb0 | (lv & 8'h40));
		timer_out <= tv;
		pwm_out <= pv;
		timer_global_enable <= 1'b1;
		timer_compare_select <= 8'h0c;
		timer_overflow_toggle <= 8'h80;
		timer_action_routed <= 8'hff;
		pwm_channel_enable <= 8'h17;
		// Five-channel PWM here, so routing bit 4 may be set
		bus(1'b1, 3'h7, 8'h1b);
		pad(8'hdf, (pv & 8'h13) | (tv & 8'h8c) | (lv & 8'h40), 24'h0f2000);
		bus(1'b0, 3'h2, 8'h40);
		timer_global_enable <= 1'b0;
		pwm_channel_enable <= 8'h00;
		pad(8'h40, lv & 8'h40, 24'h00b00f);
		print_verdict;
	end
endmodule
